// [core/ioh_core.sv]
// io unit return-signal generator toward its controlling host
// Function
// - drive two-bit condition code at end of each io operation
// - config response after connect only when control register parity is good
// - same response acknowledges set-translation when connected and both masks good
// - general response on cc valid, load done, interrupt stored, logout done
// - check response on parity error from host control bus
// - time-out reset while instruction pending but unit busy moving data
// - prefix lockout on no storage reply or stopped storage module
// - test-load complete once the requested backspace finishes
// - io processor can drive the external interrupt request line
// - signal host on each channel branch command
// - signal host on each interrecord gap
// - element check pulse on mask parity error or logout-needing error
// - element check held level when common-logic logout cannot complete
// - battery line static on battery, pulsed on connect parity error
// - temperature alarm line follows out-of-bounds thermal sense
// - io interrupt request on status change only for enabled channels
// - wait for permit, then store status, address, mask bits 16-19
// - common logic error halts unit and raises machine-check request when idle or running an instruction
// - time-out reset held during logout; host waits response then swaps status
// - backspace moves the test tape back exactly one record
`timescale 1ns/1ps
module ioh_core #(
  parameter int N_CHAN    = ioh_pkg::N_CHAN,
  parameter int PULSE_CYC = ioh_pkg::PULSE_CYC
) (
  input  wire logic                         clk,
  input  wire logic                         reset,
  // host side requests
  input  wire logic                         instr_req,
  input  wire logic                         initial_load_done,
  input  wire logic                         io_permit,
  input  wire logic                         mc_permit,
  input  wire logic                         backspace_req,
  input  wire logic [ioh_pkg::SMASK_W-1:0]  sysmask,
  input  wire logic [N_CHAN-1:0]            chan_mask,
  // unit internal events
  input  wire logic                         instr_done,
  input  wire logic [ioh_pkg::CC_W-1:0]     instr_cc,
  input  wire logic                         data_busy,
  input  wire logic                         config_connect,
  input  wire logic                         config_parity_ok,
  input  wire logic                         set_translation,
  input  wire logic                         host_connected,
  input  wire logic                         mask1_ok,
  input  wire logic                         mask2_ok,
  input  wire logic                         bus_parity_err,
  input  wire logic                         prefix_access,
  input  wire logic                         storage_no_reply,
  input  wire logic                         storage_stopped,
  input  wire logic                         io_proc_ext_irq,
  input  wire logic                         channel_branch_cmd,
  input  wire logic                         record_gap,
  input  wire logic                         logout_error,
  input  wire logic                         on_battery,
  input  wire logic                         temp_out_of_bounds,
  input  wire logic [N_CHAN-1:0]            chan_status_change,
  input  wire logic                         store_done,
  input  wire logic                         common_logic_error,
  input  wire logic                         logout_done,
  input  wire logic                         logout_blocked,
  // return lines to host
  output logic [ioh_pkg::CC_W-1:0]          condition_code,
  output logic                              config_resp,
  output logic                              response,
  output logic                              check_resp,
  output logic                              timeout_reset,
  output logic                              prefix_lockout,
  output logic                              test_load_done,
  output logic                              ext_irq_req,
  output logic                              channel_branch,
  output logic                              gap,
  output logic                              unit_error_flag,
  output logic                              battery_flag,
  output logic                              temp_alarm,
  output logic                              io_irq_req,
  output logic                              mc_irq_req,
  // unit internal commands
  output logic                              unit_halt,
  output logic                              logout_go,
  output logic                              tape_step_back,
  output logic                              status_store_go,
  output logic [ioh_pkg::CH_IDX_W-1:0]      status_store_ch,
  output logic [ioh_pkg::SMASK_W-1:0]       status_store_mask
);
  ioh_pkg::ioh_state_t st_r, st_nxt;
  logic [ioh_pkg::CC_W-1:0] cc_r, cc_nxt;
  logic resp_r, resp_nxt;
  logic cfg_r, cfg_nxt;
  logic chk_r, chk_nxt;
  logic tor_r, tor_nxt;
  logic lock_r, lock_nxt;
  logic tld_r, tld_nxt;
  logic ext_r, ext_nxt;
  logic tic_r, tic_nxt;
  logic gap_r, gap_nxt;
  logic temp_r, temp_nxt;
  logic mcr_r, mcr_nxt;
  logic halt_r, halt_nxt;
  logic lgo_r, lgo_nxt;
  logic step_r, step_nxt;
  logic seen_r, seen_nxt;
  logic elc_hold_r, elc_hold_nxt;
  logic elc_trig, bat_trig;

  ioh_irq_if #(.N(N_CHAN), .IW(ioh_pkg::CH_IDX_W)) irq_bus ();

  assign irq_bus.change     = chan_status_change;
  assign irq_bus.chmask     = chan_mask;
  assign irq_bus.sysmask    = sysmask;
  assign irq_bus.permit     = io_permit;
  assign irq_bus.store_done = store_done;
  assign irq_bus.halt       = halt_r;

  ioh_irq #(.N(N_CHAN), .IW(ioh_pkg::CH_IDX_W)) u_irq (
    .clk   (clk),
    .reset (reset),
    .bus   (irq_bus.irq)
  );

  // element check: pulse per event, level once logout is impossible
  assign elc_trig = (set_translation && !(mask1_ok && mask2_ok)) || logout_error;
  assign bat_trig = config_connect && !config_parity_ok;

  ioh_pulse #(.LEN(PULSE_CYC)) u_elc (
    .clk   (clk),
    .reset (reset),
    .trig  (elc_trig),
    .hold  (elc_hold_r),
    .out   (unit_error_flag)
  );

  ioh_pulse #(.LEN(PULSE_CYC)) u_bat (
    .clk   (clk),
    .reset (reset),
    .trig  (bat_trig),
    .hold  (on_battery),
    .out   (battery_flag)
  );

  always_comb begin
    st_nxt       = st_r;
    cc_nxt       = cc_r;
    tor_nxt      = 1'b0;
    mcr_nxt      = 1'b0;
    halt_nxt     = halt_r;
    lgo_nxt      = 1'b0;
    step_nxt     = 1'b0;
    tld_nxt      = 1'b0;
    elc_hold_nxt = elc_hold_r;
    // instruction line stays up until answered; do not run it twice
    seen_nxt     = seen_r && instr_req;
    resp_nxt     = initial_load_done || irq_bus.done;
    case (st_r)
      ioh_pkg::ST_IDLE: begin
        if (common_logic_error) begin
          halt_nxt = 1'b1;
          mcr_nxt  = 1'b1;
          st_nxt   = ioh_pkg::ST_MC_REQ;
        end else if (instr_req && !seen_r) begin
          st_nxt = ioh_pkg::ST_INSTR;
        end else if (backspace_req) begin
          step_nxt = 1'b1;
          st_nxt   = ioh_pkg::ST_BKSP;
        end
      end
      ioh_pkg::ST_INSTR: begin
        if (common_logic_error) begin
          halt_nxt = 1'b1;
          mcr_nxt  = 1'b1;
          st_nxt   = ioh_pkg::ST_MC_REQ;
        end else if (instr_done) begin
          cc_nxt   = instr_cc;
          resp_nxt = 1'b1;
          seen_nxt = 1'b1;
          st_nxt   = ioh_pkg::ST_IDLE;
        end else begin
          tor_nxt = data_busy;
        end
      end
      ioh_pkg::ST_MC_REQ: begin
        mcr_nxt = 1'b1;
        if (mc_permit) begin
          mcr_nxt = 1'b0;
          lgo_nxt = 1'b1;
          tor_nxt = 1'b1;
          st_nxt  = ioh_pkg::ST_LOGOUT;
        end
      end
      ioh_pkg::ST_LOGOUT: begin
        tor_nxt = 1'b1;
        if (logout_blocked) begin
          elc_hold_nxt = 1'b1;
          tor_nxt      = 1'b0;
          halt_nxt     = 1'b0;
          st_nxt       = ioh_pkg::ST_IDLE;
        end else if (logout_done) begin
          resp_nxt = 1'b1;
          tor_nxt  = 1'b0;
          halt_nxt = 1'b0;
          st_nxt   = ioh_pkg::ST_IDLE;
        end
      end
      ioh_pkg::ST_BKSP: begin
        // one record back: the first gap seen ends the move
        if (record_gap) begin
          tld_nxt = 1'b1;
          st_nxt  = ioh_pkg::ST_IDLE;
        end
      end
      default: st_nxt = ioh_pkg::ST_IDLE;
    endcase
  end

  always_comb begin
    cfg_nxt  = (config_connect && config_parity_ok)
               || (set_translation && host_connected && mask1_ok && mask2_ok);
    chk_nxt  = bus_parity_err;
    lock_nxt = prefix_access && (storage_no_reply || storage_stopped);
    ext_nxt  = io_proc_ext_irq;
    tic_nxt  = channel_branch_cmd;
    gap_nxt  = record_gap;
    temp_nxt = temp_out_of_bounds;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r       <= ioh_pkg::ST_IDLE;
      cc_r       <= ioh_pkg::CC_RST;
      resp_r     <= 1'b0;
      tor_r      <= 1'b0;
      mcr_r      <= 1'b0;
      halt_r     <= 1'b0;
      lgo_r      <= 1'b0;
      step_r     <= 1'b0;
      tld_r      <= 1'b0;
      seen_r     <= 1'b0;
      elc_hold_r <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      cc_r       <= cc_nxt;
      resp_r     <= resp_nxt;
      tor_r      <= tor_nxt;
      mcr_r      <= mcr_nxt;
      halt_r     <= halt_nxt;
      lgo_r      <= lgo_nxt;
      step_r     <= step_nxt;
      tld_r      <= tld_nxt;
      seen_r     <= seen_nxt;
      elc_hold_r <= elc_hold_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_r  <= 1'b0;
      chk_r  <= 1'b0;
      lock_r <= 1'b0;
      ext_r  <= 1'b0;
      tic_r  <= 1'b0;
      gap_r  <= 1'b0;
      temp_r <= 1'b0;
    end else begin
      cfg_r  <= cfg_nxt;
      chk_r  <= chk_nxt;
      lock_r <= lock_nxt;
      ext_r  <= ext_nxt;
      tic_r  <= tic_nxt;
      gap_r  <= gap_nxt;
      temp_r <= temp_nxt;
    end
  end

  assign condition_code    = cc_r;
  assign config_resp       = cfg_r;
  assign response          = resp_r;
  assign check_resp        = chk_r;
  assign timeout_reset     = tor_r;
  assign prefix_lockout    = lock_r;
  assign test_load_done    = tld_r;
  assign ext_irq_req       = ext_r;
  assign channel_branch    = tic_r;
  assign gap               = gap_r;
  assign temp_alarm        = temp_r;
  assign io_irq_req        = irq_bus.req;
  assign mc_irq_req        = mcr_r;
  assign unit_halt         = halt_r;
  assign logout_go         = lgo_r;
  assign tape_step_back    = step_r;
  assign status_store_go   = irq_bus.store_go;
  assign status_store_ch   = irq_bus.store_ch;
  assign status_store_mask = irq_bus.store_mask;

  a_cc_loaded: assert property (@(posedge clk) disable iff (reset)
    (st_r == ioh_pkg::ST_INSTR && instr_done && !common_logic_error)
    |=> response && condition_code == $past(instr_cc)) else $error("cc not loaded");
  a_cfg_parity: assert property (@(posedge clk) disable iff (reset)
    (config_connect && !config_parity_ok && !set_translation) |=> !config_resp)
    else $error("config response despite parity error");
  a_set_translation_ack: assert property (@(posedge clk) disable iff (reset)
    (set_translation && !(host_connected && mask1_ok && mask2_ok) && !config_connect)
    |=> !config_resp) else $error("translation ack without good masks");
  a_check_resp: assert property (@(posedge clk) disable iff (reset)
    bus_parity_err |=> check_resp) else $error("bus parity error not reported");
  a_busy_tor: assert property (@(posedge clk) disable iff (reset)
    (st_r == ioh_pkg::ST_INSTR && data_busy && !instr_done && !common_logic_error)
    |=> timeout_reset) else $error("no time-out reset while busy");
  a_lockout: assert property (@(posedge clk) disable iff (reset)
    prefix_access && storage_stopped |=> prefix_lockout) else $error("lockout missing");
  a_bksp_done: assert property (@(posedge clk) disable iff (reset)
    test_load_done |-> $past(st_r) == ioh_pkg::ST_BKSP && $past(record_gap))
    else $error("test-load done without a record");
  a_elc_level: assert property (@(posedge clk) disable iff (reset)
    (st_r == ioh_pkg::ST_LOGOUT && logout_blocked) |=> ##1 unit_error_flag [*8])
    else $error("element check not held");
  a_mc_request: assert property (@(posedge clk) disable iff (reset)
    (st_r == ioh_pkg::ST_IDLE && common_logic_error) |=> mc_irq_req && unit_halt)
    else $error("machine-check request missing");
  a_logout_tor: assert property (@(posedge clk) disable iff (reset)
    $rose(logout_go) |-> timeout_reset throughout (##[0:1] 1'b1))
    else $error("time-out reset dropped at logout start");
endmodule : ioh_core

// [core/ioh_pkg.sv]
// shared constants and state types for the io unit return-signal block
package ioh_pkg;
  localparam int          CLK_NS     = 5;
  localparam int          PULSE_NS   = 100;
  localparam int          PULSE_CYC  = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int          N_CHAN     = 8;
  localparam int          CC_W       = 2;
  localparam int          SMASK_W    = 4;
  localparam int          SMASK_LSB  = 16;
  localparam logic [1:0]  CC_RST     = 2'h0;
  localparam int          CH_IDX_W   = 3;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_INSTR  = 3'h1,
    ST_MC_REQ = 3'h3,
    ST_LOGOUT = 3'h2,
    ST_BKSP   = 3'h6
  } ioh_state_t;

  typedef enum logic [1:0] {
    IR_IDLE  = 2'h0,
    IR_WAIT  = 2'h1,
    IR_STORE = 2'h3
  } ioh_irq_state_t;
endpackage : ioh_pkg

// [core/ioh_irq_if.sv]
// carrier between the core and its io interrupt sequencer
`timescale 1ns/1ps
interface ioh_irq_if #(parameter int N = 8, parameter int IW = 3);
  logic [N-1:0]  change;
  logic [N-1:0]  chmask;
  logic [3:0]    sysmask;
  logic          permit;
  logic          store_done;
  logic          halt;
  logic          req;
  logic          done;
  logic          store_go;
  logic [IW-1:0] store_ch;
  logic [3:0]    store_mask;

  modport core (output change, output chmask, output sysmask, output permit,
                output store_done, output halt, input req, input done,
                input store_go, input store_ch, input store_mask);
  modport irq  (input change, input chmask, input sysmask, input permit,
                input store_done, input halt, output req, output done,
                output store_go, output store_ch, output store_mask);
endinterface : ioh_irq_if

// [core/ioh_pulse.sv]
// fixed-length pulse driver with an override level
`timescale 1ns/1ps
module ioh_pulse #(
  parameter int LEN = 20
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic trig,
  input  wire logic hold,
  output logic      out
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        out_r;
  logic        out_nxt;

  always_comb begin
    cnt_nxt = (cnt_r != 16'h0000) ? cnt_r - 16'h0001 : 16'h0000;
    if (trig) begin
      cnt_nxt = 16'(LEN - 1);
    end
    out_nxt = hold | trig | (cnt_r != 16'h0000);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_r <= 16'h0000;
      out_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign out = out_r;

  a_pulse_starts: assert property (@(posedge clk) disable iff (reset)
    trig |=> out) else $error("pulse did not start after trigger");
  // a retrigger or hold in the last cycle legally stretches the pulse
  a_pulse_ends: assert property (@(posedge clk) disable iff (reset)
    (cnt_r == 16'h0001 && !hold && !trig) ##1 (!hold && !trig) |=> !out)
    else $error("pulse overran its length");
endmodule : ioh_pulse

// [core/ioh_irq.sv]
// io interrupt request, permit wait and status store sequencing
`timescale 1ns/1ps
module ioh_irq #(
  parameter int N  = 8,
  parameter int IW = 3
) (
  input  wire logic clk,
  input  wire logic reset,
  ioh_irq_if.irq    bus
);
  ioh_pkg::ioh_irq_state_t st_r, st_nxt;
  logic [N-1:0]  pend_r, pend_nxt;
  logic [IW-1:0] ch_r, ch_nxt;
  logic [3:0]    mask_r, mask_nxt;
  logic          go_r, go_nxt;
  logic          done_r, done_nxt;
  logic [N-1:0]  live;
  logic [N-1:0]  clr;
  logic [IW-1:0] pick;

  always_comb begin
    live     = pend_r & bus.chmask;
    pick     = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (live[i]) pick = IW'(i);
    end
    st_nxt   = st_r;
    ch_nxt   = ch_r;
    mask_nxt = mask_r;
    go_nxt   = 1'b0;
    done_nxt = 1'b0;
    clr      = '0;
    case (st_r)
      ioh_pkg::IR_IDLE: begin
        if (|live && !bus.halt) st_nxt = ioh_pkg::IR_WAIT;
      end
      ioh_pkg::IR_WAIT: begin
        if (bus.permit && |live) begin
          ch_nxt    = pick;
          mask_nxt  = bus.sysmask;
          go_nxt    = 1'b1;
          clr[pick] = 1'b1;
          st_nxt    = ioh_pkg::IR_STORE;
        end else if (!(|live) || bus.halt) begin
          st_nxt = ioh_pkg::IR_IDLE;
        end
      end
      ioh_pkg::IR_STORE: begin
        if (bus.store_done) begin
          done_nxt = 1'b1;
          st_nxt   = ioh_pkg::IR_IDLE;
        end
      end
      default: st_nxt = ioh_pkg::IR_IDLE;
    endcase
    // a change arriving with its own clear stays pending
    pend_nxt = (pend_r & ~clr) | bus.change;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r   <= ioh_pkg::IR_IDLE;
      pend_r <= '0;
      ch_r   <= '0;
      mask_r <= 4'h0;
      go_r   <= 1'b0;
      done_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      pend_r <= pend_nxt;
      ch_r   <= ch_nxt;
      mask_r <= mask_nxt;
      go_r   <= go_nxt;
      done_r <= done_nxt;
    end
  end

  assign bus.req        = (st_r == ioh_pkg::IR_WAIT) && |live;
  assign bus.done       = done_r;
  assign bus.store_go   = go_r;
  assign bus.store_ch   = ch_r;
  assign bus.store_mask = mask_r;

  a_irq_masked: assert property (@(posedge clk) disable iff (reset)
    bus.req |-> |(pend_r & bus.chmask)) else $error("request for masked channel");
  a_irq_raised: assert property (@(posedge clk) disable iff (reset)
    (|live && !bus.halt && st_r == ioh_pkg::IR_IDLE)
    |=> bus.req || !(|live) || bus.halt) else $error("enabled change not requested");
  a_store_permit: assert property (@(posedge clk) disable iff (reset)
    $rose(go_r) |-> $past(bus.permit)) else $error("store without permit");
endmodule : ioh_irq

// [tb/ioh_host.sv]
// host model facing the io unit: instruction line and interrupt permits
`timescale 1ns/1ps
module ioh_host #(
  parameter int UNIT = 1
) (
  input  wire logic  clk,
  input  wire logic  reset,
  input  wire logic  go_instr,
  input  wire logic  permit_en,
  input  wire logic  response,
  input  wire logic  io_irq_req,
  input  wire logic  mc_irq_req,
  output logic       instr_req,
  output logic       io_permit,
  output logic       mc_permit,
  output logic [1:0] mc_unit_code
);
  logic [1:0] mc_s;
  logic [2:0] mc_units;
  logic [1:0] mc_pick;

  // only this unit is wired; the other two request lines stay low
  assign mc_units = 3'(mc_s[0]) << (UNIT - 1);

  // unit three is served before two, two before one
  always_comb begin
    mc_pick = 2'h0;
    if (mc_units[0]) mc_pick = 2'h1;
    if (mc_units[1]) mc_pick = 2'h2;
    if (mc_units[2]) mc_pick = 2'h3;
  end

  // edge detect after sync, so one request earns exactly one permit
  always_ff @(posedge clk) begin
    if (reset) begin
      instr_req <= 1'b0;
      io_permit <= 1'b0;
      mc_permit <= 1'b0;
      mc_s <= 2'h0;
      mc_unit_code <= 2'h0;
    end else begin
      if (mc_s[0] & ~mc_s[1]) begin
        mc_unit_code <= mc_pick;
      end
      if (go_instr) begin
        instr_req <= 1'b1;
      end else if (response) begin
        instr_req <= 1'b0;
      end
      io_permit <= permit_en & io_irq_req;
      mc_s <= {mc_s[0], mc_irq_req};
      mc_permit <= mc_s[0] & ~mc_s[1];
    end
  end
endmodule : ioh_host

// [tb/tb_io_unit_host_signaling.sv]
// self-checking bench for the io unit return-signal block
`timescale 1ns/1ps
`define CHK(nm, e, g) chk(nm, 8'(e), 8'(g))
`define PULSE(s) @(posedge clk); s <= 1'b1; @(posedge clk); s <= 1'b0; @(negedge clk)
module tb_io_unit_host_signaling;
  localparam int PC = 2;
  logic clk, reset, instr_req, initial_load_done, io_permit, mc_permit, backspace_req;
  logic [3:0] sysmask, status_store_mask;
  logic [7:0] chan_mask, chan_status_change;
  logic instr_done, data_busy, config_connect, config_parity_ok, set_translation;
  logic host_connected, mask1_ok, mask2_ok, bus_parity_err, prefix_access, gap;
  logic storage_no_reply, storage_stopped, io_proc_ext_irq, channel_branch_cmd, record_gap;
  logic logout_error, on_battery, temp_out_of_bounds, store_done, common_logic_error;
  logic logout_done, logout_blocked, config_resp, response, check_resp, timeout_reset;
  logic prefix_lockout, test_load_done, ext_irq_req, channel_branch, unit_error_flag;
  logic battery_flag, temp_alarm, io_irq_req, mc_irq_req, unit_halt, logout_go;
  logic tape_step_back, status_store_go, go_instr, permit_en;
  logic [1:0] instr_cc, condition_code, mc_unit_code;
  logic [2:0] status_store_ch;
  logic [31:0] rnd;
  int errors, num_checks, n;

  // short pulse length keeps the element check runs brief
  ioh_core #(.PULSE_CYC(PC)) DUT (.*);
  ioh_host host (.*);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task report_and_stop();
    if (errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // bounded wait, sampled on the falling edge where outputs are settled
  task automatic wait_hi(ref logic s, input string nm);
    for (n = 0; n < 60 && s !== 1'b1; n++) @(negedge clk);
    if (s !== 1'b1) begin
      errors++;
      $display("unexpected %s expected 1 seen %b", nm, s);
      report_and_stop();
    end
  endtask : wait_hi

  initial begin
    {go_instr, permit_en, initial_load_done, backspace_req, sysmask, chan_mask, instr_done,
     instr_cc, data_busy, config_connect, config_parity_ok, set_translation, host_connected,
     mask1_ok, mask2_ok, bus_parity_err, prefix_access, storage_no_reply, storage_stopped,
     io_proc_ext_irq, channel_branch_cmd, record_gap, logout_error, on_battery,
     temp_out_of_bounds, chan_status_change, store_done, common_logic_error, logout_done,
     logout_blocked} = '0;
    errors = 0;
    num_checks = 0;
    rnd = 32'h0000_d467;
    reset = 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    `CHK("quiet", {condition_code, response, timeout_reset, mc_irq_req, io_irq_req}, 0);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      @(posedge clk);
      go_instr <= 1'b1;
      data_busy <= rnd[0];
      instr_cc <= 2'(i);
      @(posedge clk);
      go_instr <= 1'b0;
      repeat (5) @(negedge clk);
      `CHK("timeout_reset", rnd[0], timeout_reset);
      `PULSE(instr_done);
      `CHK("response", 1, response);
      `CHK("condition_code", i, condition_code);
      repeat (3) @(negedge clk);
    end
    @(posedge clk);
    data_busy <= 1'b0;
    // random level and pulse lines, each returned one cycle late
    repeat (24) begin
      rnd = lfsr(rnd);
      @(posedge clk);
      {bus_parity_err, prefix_access, storage_no_reply, storage_stopped, io_proc_ext_irq,
       channel_branch_cmd, record_gap, temp_out_of_bounds} <= rnd[7:0];
      @(posedge clk);
      @(negedge clk);
      `CHK("check_resp", rnd[7], check_resp);
      `CHK("prefix_lockout", rnd[6] & (rnd[5] | rnd[4]), prefix_lockout);
      `CHK("ext_irq_req", rnd[3], ext_irq_req);
      `CHK("channel_branch", rnd[2], channel_branch);
      `CHK("gap", rnd[1], gap);
      `CHK("temp_alarm", rnd[0], temp_alarm);
    end
    @(posedge clk);
    {bus_parity_err, prefix_access, io_proc_ext_irq, channel_branch_cmd, record_gap} <= '0;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      config_parity_ok <= i[0];
      {host_connected, mask1_ok, mask2_ok} <= 3'(i);
      `PULSE(config_connect);
      `CHK("config_resp", i[0], config_resp);
      `CHK("battery_flag", !i[0], battery_flag);
      repeat (4) @(negedge clk);
      `CHK("battery_flag", 0, battery_flag);
      `PULSE(set_translation);
      `CHK("config_resp", i == 7, config_resp);
      `CHK("unit_error_flag", i[1:0] != 2'h3, unit_error_flag);
      repeat (4) @(negedge clk);
    end
    `PULSE(logout_error);
    `CHK("unit_error_flag", 1, unit_error_flag);
    repeat (PC) @(negedge clk);
    `CHK("unit_error_flag", 0, unit_error_flag);
    @(posedge clk);
    on_battery <= 1'b1;
    repeat (10) @(negedge clk);
    `CHK("battery_flag", 1, battery_flag);
    @(posedge clk);
    on_battery <= 1'b0;
    `PULSE(backspace_req);
    `CHK("tape_step_back", 1, tape_step_back);
    repeat (3) @(negedge clk);
    `CHK("test_load_done", 0, test_load_done);
    `PULSE(record_gap);
    `CHK("test_load_done", 1, test_load_done);
    // status change on a masked-off channel must wait for its mask
    rnd = lfsr(rnd);
    @(posedge clk);
    sysmask <= rnd[3:0];
    chan_status_change <= 8'h01 << rnd[6:4];
    @(posedge clk);
    chan_status_change <= 8'h00;
    repeat (4) @(negedge clk);
    `CHK("io_irq_req", 0, io_irq_req);
    @(posedge clk);
    chan_mask <= rnd[15:8] | (8'h01 << rnd[6:4]);
    repeat (3) @(negedge clk);
    `CHK("io_irq_req", 1, io_irq_req);
    @(posedge clk);
    permit_en <= 1'b1;
    wait_hi(status_store_go, "status_store_go");
    `CHK("status_store_ch", rnd[6:4], status_store_ch);
    `CHK("status_store_mask", rnd[3:0], status_store_mask);
    @(posedge clk);
    permit_en <= 1'b0;
    `PULSE(store_done);
    // store completion passes the sequencer's done flop, so one cycle later
    @(negedge clk);
    `CHK("response", 1, response);
    `PULSE(initial_load_done);
    `CHK("response", 1, response);
    `PULSE(common_logic_error);
    `CHK("mc_irq_req", 1, mc_irq_req);
    `CHK("unit_halt", 1, unit_halt);
    wait_hi(logout_go, "logout_go");
    @(negedge clk);
    `CHK("timeout_reset", 1, timeout_reset);
    `CHK("mc_irq_req", 0, mc_irq_req);
    `CHK("mc_unit_code", 2'h1, mc_unit_code);
    `PULSE(logout_done);
    `CHK("response", 1, response);
    `CHK("unit_halt", 0, unit_halt);
    // logout that cannot finish leaves element check as a level
    `PULSE(common_logic_error);
    wait_hi(logout_go, "logout_go");
    `PULSE(logout_blocked);
    repeat (8) @(negedge clk);
    `CHK("unit_error_flag", 1, unit_error_flag);
    `PULSE(reset);
    `CHK("unit_error_flag", 0, unit_error_flag);
    report_and_stop();
  end
endmodule : tb_io_unit_host_signaling
